// file: pkg/csb_pkg.sv
// Package with constants, types and the register map of the compare, skip and branch unit.
package csb_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned PC_W   = 16;
  localparam int unsigned OFF_W  = 7;
  localparam int unsigned ADDR_W = 8;

  // ---------------------------------------------------------------------------
  // Status flag bit positions
  // ---------------------------------------------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_H = 5;

  // ---------------------------------------------------------------------------
  // Program counter steps
  // ---------------------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_STEP       = 16'h0001;
  localparam logic [PC_W-1:0] PC_SKIP_SHORT = 16'h0002;
  localparam logic [PC_W-1:0] PC_SKIP_LONG  = 16'h0003;

  // ---------------------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FLAGS  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PC     = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RESULT = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_STAT   = 8'h10;
  localparam int unsigned       CTRL_EN    = 0;
  localparam int unsigned       STAT_TAKEN = 0;
  localparam int unsigned       STAT_CMP   = 1;
  localparam logic [7:0]        CTRL_RST   = 8'h00;
  localparam logic [7:0]        FLAGS_RST  = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST     = 16'h0000;

  // ---------------------------------------------------------------------------
  // Operations
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    compare_reg_op,
    compare_carry_op,
    compare_immediate_op,
    skip_reg_bit_clear_op,
    skip_reg_bit_set_op,
    skip_io_bit_clear_op,
    skip_io_bit_set_op,
    branch_flag_set_op,
    branch_flag_clear_op,
    branch_equal_op,
    branch_not_equal_op,
    branch_carry_set_op,
    branch_carry_clear_op,
    branch_same_higher_op,
    branch_lower_op,
    branch_negative_op,
    branch_positive_op
  } csb_op_e;

  typedef struct packed {
    logic             valid;
    csb_op_e          op;
    logic [7:0]       dst_val;
    logic [7:0]       source_register;
    logic [7:0]       imm_val;
    logic [7:0]       io_val;
    logic [2:0]       bit_sel;
    logic [OFF_W-1:0] offset;
    logic             next_long;
  } csb_issue_s;

  typedef struct packed {
    logic            done;
    logic            taken;
    logic [PC_W-1:0] pc;
  } csb_result_s;

endpackage

// file: rtl/csb_unit.sv
// Compare, conditional skip and conditional branch execution unit with an APB register file.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none

module csb_unit (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         clk_en,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [csb_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output var  logic [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire csb_pkg::csb_issue_s          issue_i,
  output logic                              issue_ready,
  output var  csb_pkg::csb_result_s         result_o,
  output var  logic [7:0]                   flags_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [7:0]               ctrl_r;
  logic [7:0]               flags_r;
  logic [7:0]               flags_nxt;
  logic [csb_pkg::PC_W-1:0] pc_r;
  logic [csb_pkg::PC_W-1:0] pc_nxt;
  logic [7:0]               diff_r;
  logic [7:0]               diff_nxt;
  logic                     taken_r;
  logic                     taken_nxt;
  logic                     cmp_r;
  logic                     is_cmp;
  logic                     exec;
  logic [7:0]               sub_a;
  logic [7:0]               sub_b;
  logic                     sub_cin;
  logic                     bit_val;
  logic                     cond;
  logic                     is_skip;
  logic [csb_pkg::PC_W-1:0] off_ext;
  logic                     apb_wr;
  logic                     apb_setup;
  logic                     addr_ok;
  logic [31:0]              rd_mux;

  assign issue_ready = ctrl_r[csb_pkg::CTRL_EN];
  assign exec        = clk_en && issue_i.valid && issue_ready;
  assign flags_o     = flags_r;

  // ---------------------------------------------------------------------------
  // Compare datapath
  // ---------------------------------------------------------------------------
  always_comb begin
    sub_a   = issue_i.dst_val;
    sub_b   = issue_i.source_register;
    sub_cin = 1'b0;
    is_cmp  = 1'b0;
    unique case (issue_i.op)
      csb_pkg::compare_reg_op: begin
        is_cmp = 1'b1;
      end
      csb_pkg::compare_carry_op: begin
        is_cmp  = 1'b1;
        sub_cin = flags_r[csb_pkg::FLAG_C];
      end
      csb_pkg::compare_immediate_op: begin
        is_cmp = 1'b1;
        sub_b  = issue_i.imm_val;
      end
      default: begin
        is_cmp = 1'b0;
      end
    endcase
  end

  // The difference is only reported and feeds the flags; no register is written.
  always_comb begin
    diff_nxt  = sub_a - sub_b - {7'h00, sub_cin};
    flags_nxt = flags_r;
    flags_nxt[csb_pkg::FLAG_Z] = (diff_nxt == 8'h00);
    flags_nxt[csb_pkg::FLAG_N] = diff_nxt[7];
    flags_nxt[csb_pkg::FLAG_V] = (sub_a[7] & ~sub_b[7] & ~diff_nxt[7])
                               | (~sub_a[7] & sub_b[7] & diff_nxt[7]);
    flags_nxt[csb_pkg::FLAG_C] = (~sub_a[7] & sub_b[7]) | (sub_b[7] & diff_nxt[7])
                               | (diff_nxt[7] & ~sub_a[7]);
    flags_nxt[csb_pkg::FLAG_H] = (~sub_a[3] & sub_b[3]) | (sub_b[3] & diff_nxt[3])
                               | (diff_nxt[3] & ~sub_a[3]);
  end

  // ---------------------------------------------------------------------------
  // Skip and branch conditions
  // ---------------------------------------------------------------------------
  always_comb begin
    bit_val = 1'b0;
    cond    = 1'b0;
    is_skip = 1'b0;
    unique case (issue_i.op)
      csb_pkg::skip_reg_bit_clear_op: begin
        is_skip = 1'b1;
        cond    = ~issue_i.source_register[issue_i.bit_sel];
      end
      csb_pkg::skip_reg_bit_set_op: begin
        is_skip = 1'b1;
        cond    = issue_i.source_register[issue_i.bit_sel];
      end
      csb_pkg::skip_io_bit_clear_op: begin
        is_skip = 1'b1;
        cond    = ~issue_i.io_val[issue_i.bit_sel];
      end
      csb_pkg::skip_io_bit_set_op: begin
        is_skip = 1'b1;
        cond    = issue_i.io_val[issue_i.bit_sel];
      end
      csb_pkg::branch_flag_set_op: begin
        bit_val = flags_r[issue_i.bit_sel];
        cond    = bit_val;
      end
      csb_pkg::branch_flag_clear_op: begin
        bit_val = flags_r[issue_i.bit_sel];
        cond    = ~bit_val;
      end
      csb_pkg::branch_equal_op: begin
        cond = flags_r[csb_pkg::FLAG_Z];
      end
      csb_pkg::branch_not_equal_op: begin
        cond = ~flags_r[csb_pkg::FLAG_Z];
      end
      csb_pkg::branch_carry_set_op: begin
        cond = flags_r[csb_pkg::FLAG_C];
      end
      csb_pkg::branch_carry_clear_op: begin
        cond = ~flags_r[csb_pkg::FLAG_C];
      end
      csb_pkg::branch_same_higher_op: begin
        cond = ~flags_r[csb_pkg::FLAG_C];
      end
      csb_pkg::branch_lower_op: begin
        cond = flags_r[csb_pkg::FLAG_C];
      end
      csb_pkg::branch_negative_op: begin
        cond = flags_r[csb_pkg::FLAG_N];
      end
      csb_pkg::branch_positive_op: begin
        cond = ~flags_r[csb_pkg::FLAG_N];
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  // The offset counts words and may point backward.
  assign off_ext = {{(csb_pkg::PC_W-csb_pkg::OFF_W){issue_i.offset[csb_pkg::OFF_W-1]}},
                    issue_i.offset};

  always_comb begin
    taken_nxt = cond && !is_cmp;
    if (is_cmp || !cond) begin
      pc_nxt = pc_r + csb_pkg::PC_STEP;
    end else if (is_skip) begin
      pc_nxt = pc_r + (issue_i.next_long ? csb_pkg::PC_SKIP_LONG
                                         : csb_pkg::PC_SKIP_SHORT);
    end else begin
      pc_nxt = pc_r + off_ext + csb_pkg::PC_STEP;
    end
  end

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_wr    = clk_en && psel && penable && pwrite && addr_ok;
  assign pready    = clk_en;
  assign pslverr   = psel && penable && !addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    unique case (paddr)
      csb_pkg::REG_CTRL: begin
        rd_mux[7:0] = ctrl_r;
      end
      csb_pkg::REG_FLAGS: begin
        rd_mux[7:0] = flags_r;
      end
      csb_pkg::REG_PC: begin
        rd_mux[csb_pkg::PC_W-1:0] = pc_r;
      end
      csb_pkg::REG_RESULT: begin
        rd_mux[7:0] = diff_r;
      end
      csb_pkg::REG_STAT: begin
        rd_mux[csb_pkg::STAT_TAKEN] = taken_r;
        rd_mux[csb_pkg::STAT_CMP]   = cmp_r;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Read data is caught in the setup cycle so it is stable for the whole access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && apb_setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= csb_pkg::CTRL_RST;
    end else if (apb_wr && paddr == csb_pkg::REG_CTRL) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Flags, program counter and results
  // ---------------------------------------------------------------------------
  // An executing compare wins over a software write in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= csb_pkg::FLAGS_RST;
    end else if (exec && is_cmp) begin
      flags_r <= flags_nxt;
    end else if (apb_wr && paddr == csb_pkg::REG_FLAGS) begin
      flags_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= csb_pkg::PC_RST;
    end else if (exec) begin
      pc_r <= pc_nxt;
    end else if (apb_wr && paddr == csb_pkg::REG_PC) begin
      pc_r <= pwdata[csb_pkg::PC_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diff_r  <= 8'h00;
      taken_r <= 1'b0;
      cmp_r   <= 1'b0;
    end else if (exec) begin
      if (is_cmp) begin
        diff_r <= diff_nxt;
      end
      taken_r <= taken_nxt;
      cmp_r   <= is_cmp;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_o <= '0;
    end else if (clk_en) begin
      result_o.done  <= exec;
      result_o.taken <= exec && taken_nxt;
      result_o.pc    <= exec ? pc_nxt : pc_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_cmp_zero_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && issue_i.op == csb_pkg::compare_reg_op
      |=> flags_r[csb_pkg::FLAG_Z] == (diff_r == 8'h00))
    else $error("Compare zero flag does not match the difference.");

  chk_cmpc_borrow: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && issue_i.op == csb_pkg::compare_carry_op && flags_r[csb_pkg::FLAG_C]
      && issue_i.dst_val == issue_i.source_register
      |=> diff_r == 8'hff && flags_r[csb_pkg::FLAG_C] && flags_r[csb_pkg::FLAG_N])
    else $error("Compare with carry ignores the carry in.");

  chk_cmpi_diff: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && issue_i.op == csb_pkg::compare_immediate_op
      |=> diff_r == $past(issue_i.dst_val) - $past(issue_i.imm_val))
    else $error("Immediate compare difference is wrong.");

  chk_skip_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && is_skip && cond
      |=> pc_r == $past(pc_r) + ($past(issue_i.next_long) ? 16'h0003 : 16'h0002))
    else $error("Skip does not advance the counter by two or three.");

  chk_skip_io_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && issue_i.op == csb_pkg::skip_io_bit_set_op && !issue_i.io_val[issue_i.bit_sel]
      |=> pc_r == $past(pc_r) + 16'h0001 && !taken_r)
    else $error("I/O bit set skip taken on a zero bit.");

  chk_branch_eq: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && issue_i.op == csb_pkg::branch_equal_op && flags_r[csb_pkg::FLAG_Z]
      |=> pc_r == $past(pc_r) + $past(off_ext) + 16'h0001 && result_o.taken)
    else $error("Branch on equal not taken with zero flag set.");

  chk_branch_lower: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && issue_i.op == csb_pkg::branch_lower_op && !flags_r[csb_pkg::FLAG_C]
      |=> !taken_r && pc_r == $past(pc_r) + 16'h0001)
    else $error("Branch on lower taken with carry clear.");

  chk_branch_back: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && !is_cmp && !is_skip && cond && issue_i.offset[csb_pkg::OFF_W-1]
      |=> $signed(pc_r - $past(pc_r)) <= 16'sh0000)
    else $error("Negative offset did not move the counter back.");

  chk_flags_kept: assert property (
    @(posedge pclk) disable iff (!presetn)
    exec && !is_cmp |=> $stable(flags_r))
    else $error("Skip or branch altered the status flags.");

endmodule

`default_nettype wire

// file: tb/csb_fetch_model.sv
// Behavioural fetch pipeline that presents one instruction at a time to the unit.
`timescale 1ns/1ns
`default_nettype none
module csb_fetch_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  input  wire logic                go_i,
  input  wire csb_pkg::csb_issue_s req_i,
  input  wire logic                issue_ready,
  output var  csb_pkg::csb_issue_s issue_o
);
  csb_pkg::csb_issue_s nxt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      issue_o <= '0;
    end else if (issue_o.valid && issue_ready && clk_en) begin
      // Released fields toggle so a stale instruction never looks live.
      nxt = ~issue_o;
      nxt.valid = 1'b0;
      issue_o <= nxt;
    end else if (go_i) begin
      nxt = req_i;
      nxt.valid = 1'b1;
      issue_o <= nxt;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking testbench for the compare, skip and branch unit.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                pclk;
  logic                presetn;
  logic                clk_en;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic                pready;
  logic                pslverr;
  logic                go;
  logic                rdy;
  logic                et;
  logic                er;
  logic [7:0]          paddr;
  logic [7:0]          flags;
  logic [7:0]          ef;
  logic [15:0]         epc;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic [31:0]         rd;
  logic [31:0]         seed;
  logic [31:0]         t;
  csb_pkg::csb_issue_s req;
  csb_pkg::csb_issue_s iss;
  csb_pkg::csb_issue_s q;
  csb_pkg::csb_result_s res;
  int                  n_errors;
  int                  checks;
  int                  cyc;

  csb_unit u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .issue_i(iss), .issue_ready(rdy), .result_o(res),
    .flags_o(flags));

  csb_fetch_model u_fetch (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .go_i(go),
    .req_i(req), .issue_ready(rdy), .issue_o(iss));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_flags(input logic [7:0] v);
    apb(1'b1, csb_pkg::REG_FLAGS, {24'h000000, v});
    ef = v;
  endtask

  // ---------------------------------------------------------------------------
  // Expected flags, program counter and taken bit of one instruction.
  // ---------------------------------------------------------------------------
  function automatic void model(input csb_pkg::csb_issue_s i, output logic tk,
                                output logic [7:0] r);
    logic [7:0] d;
    logic [7:0] s;
    logic       c;
    logic       cnd;
    logic [2:0] b;
    b = i.bit_sel;
    d = i.dst_val;
    s = (i.op == csb_pkg::compare_immediate_op) ? i.imm_val : i.source_register;
    c = (i.op == csb_pkg::compare_carry_op) ? ef[0] : 1'b0;
    r = d - s - {7'h00, c};
    case (i.op)
      csb_pkg::skip_reg_bit_clear_op: cnd = !s[b];
      csb_pkg::skip_reg_bit_set_op: cnd = s[b];
      csb_pkg::skip_io_bit_clear_op: cnd = !i.io_val[b];
      csb_pkg::skip_io_bit_set_op: cnd = i.io_val[b];
      csb_pkg::branch_flag_set_op: cnd = ef[b];
      csb_pkg::branch_flag_clear_op: cnd = !ef[b];
      csb_pkg::branch_equal_op: cnd = ef[1];
      csb_pkg::branch_not_equal_op: cnd = !ef[1];
      csb_pkg::branch_carry_set_op, csb_pkg::branch_lower_op: cnd = ef[0];
      csb_pkg::branch_carry_clear_op, csb_pkg::branch_same_higher_op: cnd = !ef[0];
      csb_pkg::branch_negative_op: cnd = ef[2];
      csb_pkg::branch_positive_op: cnd = !ef[2];
      default: begin
        cnd = 1'b0;
        ef[0] = (~d[7] & s[7]) | (s[7] & r[7]) | (r[7] & ~d[7]);
        ef[1] = (r == 8'h00);
        ef[2] = r[7];
        ef[3] = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
        ef[5] = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
      end
    endcase
    tk = cnd;
    if (!cnd) begin
      epc = epc + 16'h0001;
    end else if (i.op <= csb_pkg::skip_io_bit_set_op) begin
      epc = epc + (i.next_long ? 16'h0003 : 16'h0002);
    end else begin
      epc = epc + {{9{i.offset[6]}}, i.offset} + 16'h0001;
    end
  endfunction

  task automatic run(input csb_pkg::csb_issue_s i);
    logic [7:0] r;
    model(i, et, r);
    @(posedge pclk);
    req <= i;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (int k = 0; k < 20; k++) begin
      @(negedge pclk);
      if (res.done === 1'b1) break;
    end
    chk("done", 32'h1, {31'h0, res.done});
    chk("flags", {24'h0, ef}, {24'h0, flags});
    chk("pc", {16'h0, epc}, {16'h0, res.pc});
    chk("taken", {31'h0, et}, {31'h0, res.taken});
    if (i.op <= csb_pkg::compare_immediate_op) begin
      apb(1'b0, csb_pkg::REG_RESULT, 32'h0);
      chk("diff", {24'h0, r}, rd);
    end
    apb(1'b0, csb_pkg::REG_STAT, 32'h0);
    chk("stat", {30'h0, i.op <= csb_pkg::compare_immediate_op, et}, rd);
  endtask

  task finish_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, go} = 5'h00;
    clk_en = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    req = '0;
    seed = 32'd90483;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    ef = 8'h00;
    epc = 16'h0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("ready", 32'h0, {31'h0, rdy});
    chk("result", 32'h0, {14'h0, res});
    apb(1'b0, csb_pkg::REG_PC, 32'h0);
    chk("pc_reset", 32'h0, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    clk_en <= 1'b0;
    @(negedge pclk);
    chk("pready", 32'h0, {31'h0, pready});
    @(posedge pclk);
    clk_en <= 1'b1;
    apb(1'b1, csb_pkg::REG_CTRL, 32'h1);
    apb(1'b1, csb_pkg::REG_PC, 32'h0000_1234);
    epc = 16'h1234;
    $display("test reset and bus done");
    for (int p = 0; p < 2; p++) begin
      for (int o = 0; o < 17; o++) begin
        set_flags(p ? 8'hff : 8'h00);
        q = '0;
        q.op = csb_pkg::csb_op_e'(o);
        q.dst_val = p ? 8'hff : 8'h80;
        q.source_register = p ? 8'hff : 8'h01;
        q.imm_val = 8'h80;
        q.io_val = p ? 8'hff : 8'h00;
        q.bit_sel = 3'(o);
        q.offset = p ? 7'h3f : 7'h40;
        q.next_long = p[0];
        run(q);
      end
    end
    $display("test corner cases done");
    for (int n = 0; n < 300; n++) begin
      t = rnd();
      if (n % 16 == 0) set_flags(t[7:0]);
      q.dst_val = t[7:0];
      q.source_register = t[15:8];
      q.imm_val = t[23:16];
      q.io_val = t[31:24];
      t = rnd();
      q.bit_sel = t[2:0];
      q.offset = t[9:3];
      q.next_long = t[10];
      q.op = csb_pkg::csb_op_e'(t[15:11] % 5'd17);
      run(q);
    end
    $display("test random operations done");
    finish_test();
  end
endmodule
`default_nettype wire
